// [bench/aisc_assertions.sv]
// Port checks for the input select block
`timescale 1ns/10ps
`default_nettype none
module aisc_chk
	import aisc_pkg::*;
#(
	parameter int NUM_INPUTS = 32
) (
	input wire logic               clk_sys,
	input wire logic               sys_rst,
	input wire logic [AISC_AW-1:0] regAddr,
	input wire logic [AISC_DW-1:0] regWrData,
	input wire logic               regWr,
	input wire logic               regRd,
	input wire logic [AISC_DW-1:0] regRdData,
	input wire logic               sampleDone,
	input wire logic [7:0]         dmaWordsPerInput,
	input wire logic               twelveBitMode,
	input wire aisc_route_t        route,
	input wire logic [31:0]        pinDigitalSelect
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_words; $onehot(dmaWordsPerInput); endproperty
	a_words: assert property (p_words)
		else $error("depth words not a power of two");
	property p_trio;
		regRd && regAddr == AISC_IDX_TRIO |=>
			(regRdData & ~AISC_TRIO_MASK) == 16'h0000;
	endproperty
	a_trio: assert property (p_trio)
		else $error("trio spare bits read nonzero");
	property p_hide;
		twelveBitMode && $past(twelveBitMode) |->
			route.trioNeg == 2'h0 && !route.trioPosHigh;
	endproperty
	a_hide: assert property (p_hide)
		else $error("trio routing live in twelve-bit mode");
	property p_echo;
		regWr && regAddr == AISC_IDX_SCANL ##1 regRd && regAddr ==
			AISC_IDX_SCANL |=> regRdData == $past(regWrData, 2);
	endproperty
	a_echo: assert property (p_echo)
		else $error("scan mask read differs from write");
	property p_slot; $rose(route.slotB) |-> $past(sampleDone, 2); endproperty
	a_slot: assert property (p_slot)
		else $error("slot moved without a sample");
	property p_absent;
		route.ch0PosToLowRef |-> route.ch0Pos >= NUM_INPUTS;
	endproperty
	a_absent: assert property (p_absent)
		else $error("low reference for a present input");
	property p_ground;
		route.ch0PosToGround && $stable(pinDigitalSelect) |->
			pinDigitalSelect[route.ch0Pos];
	endproperty
	a_ground: assert property (p_ground)
		else $error("grounded an analog pin");
	property p_pins; (pinDigitalSelect >> NUM_INPUTS) == 32'h0; endproperty
	a_pins: assert property (p_pins)
		else $error("missing pin reported digital");
	c_alt: cover property ($rose(route.slotB));
	c_low: cover property (route.ch0PosToLowRef);
	c_hide: cover property (twelveBitMode && regRd);
endmodule
`default_nettype wire

// [bench/aisc_seq_model.sv]
// Sequencer stand-in: one sample pulse per request after a set delay
`timescale 1ns/10ps
`default_nettype none
module aisc_seq_model #(
	parameter int DELAY = 1
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Bench request
	input  wire logic        step,
	// Towards the block
	output logic             sampleDone,
	output logic [11:0]      orderAddr
);
	logic [DELAY-1:0] pipe;
	assign sampleDone = pipe[DELAY-1];
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pipe <= '0;
			orderAddr <= 12'h000;
		end else begin
			pipe <= DELAY'({pipe, step});
			if (sampleDone) begin
				orderAddr <= orderAddr + 12'h001;
			end
		end
	end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the input select block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH %0t got %0h want %0h", $time, g, e); end end
module tb
	import aisc_pkg::*;
;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, regWr = 1'b0;
	logic        regRd = 1'b0, step = 1'b0, sampleDone, twelveBitMode;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000, regRdData;
	logic [11:0] orderAddr, dmaAddr;
	logic [7:0]  dmaWordsPerInput;
	logic [31:0] pinDigitalSelect;
	aisc_route_t route;
	int          err_count = 0, samples_checked = 0;
	always #4 clk_sys = ~clk_sys;
	aisc_seq_model #(.DELAY(2)) u_seq (.clk_sys, .sys_rst, .step,
		.sampleDone, .orderAddr);
	aisc_input_select #(.NUM_INPUTS(24)) dut (.clk_sys, .sys_rst, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .sampleDone, .orderAddr,
		.dmaAddr, .dmaWordsPerInput, .twelveBitMode, .route, .pinDigitalSelect);
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 `CHK(regRdData, e)
	endtask
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// Route follows a sample three edges after the pulse is taken
	task automatic smp;
		step <= 1'b1;
		@(posedge clk_sys);
		step <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic t_regs;
		logic [15:0] m [7] = '{16'h0007, 16'h0707, 16'h9F9F, 16'hFFFF,
			16'hFFFF, 16'hFFFF, 16'hFFFF};
		for (int i = 0; i < 16; i++) rd(4'(i), 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr(4'(i), 16'hFFFF);
			rd(4'(i), m[i]);
			wr(4'(i), 16'h0000);
		end
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
	endtask
	task automatic t_depth;
		for (int c = 0; c < 8; c++) begin
			wr(AISC_IDX_DEPTH, 16'(c));
			settle;
			`CHK(dmaWordsPerInput, 8'h01 << c)
		end
	endtask
	task automatic t_route;
		wr(AISC_IDX_CH0, 16'h9F85);
		wr(AISC_IDX_TRIO, 16'h0007);
		settle;
		`CHK(route, 12'h14F)
		`CHK(dmaAddr, 12'h280)
		wr(AISC_IDX_TRIO, 16'h0004);
		settle;
		`CHK(route.trioNeg, 2'h2)
		wr(AISC_IDX_MODE, 16'h0001);
		settle;
		`CHK(twelveBitMode, 1'b1)
		`CHK(route.trioNeg, 2'h0)
		rd(AISC_IDX_TRIO, 16'h0000);
		wr(AISC_IDX_MODE, 16'h0000);
	endtask
	task automatic t_alt;
		wr(AISC_IDX_CH0, 16'h8903);
		wr(AISC_IDX_TRIO, 16'h0500);
		wr(AISC_IDX_MODE, 16'h0002);
		settle;
		`CHK(route, 12'h0C0)
		smp;
		`CHK(route, 12'hA4E)
		smp;
		`CHK(route, 12'h0C0)
	endtask
	// Input 31 is absent with 24 inputs, so it must convert the reference
	task automatic t_scan;
		wr(AISC_IDX_SCANL, 16'h0005);
		wr(AISC_IDX_SCANH, 16'h8000);
		wr(AISC_IDX_PINL, 16'h0001);
		wr(AISC_IDX_MODE, 16'h0004);
		settle;
		`CHK(route.ch0PosToGround, 1'b1)
		smp;
		`CHK(route.ch0Pos, 5'h02)
		smp;
		`CHK({route.ch0Pos, route.ch0PosToLowRef}, 6'h3F)
		smp;
		`CHK(route.ch0Pos, 5'h00)
		wr(AISC_IDX_PINH, 16'hFFFF);
		settle;
		`CHK(pinDigitalSelect, 32'h00FF0001)
		wr(AISC_IDX_MODE, 16'h0008);
		settle;
		`CHK(dmaAddr, 12'h005)
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		t_regs;
		t_depth;
		t_route;
		t_alt;
		t_scan;
		conclude;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		err_count++;
		conclude;
	end
endmodule
bind aisc_input_select aisc_chk #(.NUM_INPUTS(NUM_INPUTS)) u_chk (.clk_sys,
	.sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .sampleDone,
	.dmaWordsPerInput, .twelveBitMode, .route, .pinDigitalSelect);
`default_nettype wire

// [hdl/aisc_input_select.sv]
// Converter front-end input selection, scan and pin configuration block
//
// Functional notes
// [RULE1] - depth code gives two-power words per input
// [RULE2] - depth in bits 2:0, rest read zero
// [RULE3] - slot B trio negative: 11,10, 0x reference
// [RULE4] - slot A trio negative decodes like slot B
// [RULE5] - trio positive bit picks AN3-5 or AN0-2
// [RULE6] - twelve-bit mode hides trio fields as zero
// [RULE7] - slot A first negative: AN1 or reference
// [RULE8] - slot B first negative at bit 15, same
// [RULE9] - slot A first positive equals input index
// [RULE10] - slot B first positive bits 12:8, same
// [RULE11] - 32 scan mask bits over two registers
// [RULE12] - missing scanned input converts low reference
// [RULE13] - pin digital bit grounds mux, enables reads
// [RULE14] - pin bits always writable, missing ones ignored; the second converter drops high pin writes
// [RULE15] - second converter: inputs 0-15, no high pins
// [RULE16] - fields reset zero, unimplemented bits read zero
// [RULE17] - mode bit picks twelve-bit single channel
// [RULE18] - alternate sample swaps slot A and B
// [RULE19] - scan steps first positive in slot A
// [RULE20] - scatter address from input index and depth
// [RULE21] - writes to unimplemented bits are ignored
// [RULE22] - scan ascends and wraps to lowest selected
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module aisc_input_select
	import aisc_pkg::*;
#(
	parameter int NUM_INPUTS       = 32,
	parameter bit SECOND_CONVERTER = 1'b0
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	// Register port
	input  wire logic [AISC_AW-1:0]  regAddr,
	input  wire logic [AISC_DW-1:0]  regWrData,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output logic      [AISC_DW-1:0]  regRdData,
	// Sequencing core
	input  wire logic                sampleDone,
	input  wire logic [11:0]         orderAddr,
	output logic      [11:0]         dmaAddr,
	output logic      [7:0]          dmaWordsPerInput,
	output logic                     twelveBitMode,
	// Multiplexers and port pins
	output aisc_route_t              route,
	output logic      [31:0]         pinDigitalSelect
);
	// Inputs present on this converter
	localparam int EFF_INPUTS =
		(SECOND_CONVERTER && NUM_INPUTS > 16) ? 16 : NUM_INPUTS; // [RULE15]
	localparam logic [31:0] PRESENT =
		(EFF_INPUTS >= 32) ? 32'hFFFFFFFF :
		((32'h1 << EFF_INPUTS) - 32'h1);

	typedef struct packed {
		logic [15:0] depth;
		logic [15:0] trio;
		logic [15:0] ch0;
		logic [31:0] scanMask;
		logic [31:0] pinMask;
		logic [15:0] mode;
		logic [4:0]  scanPtr;
		logic        slotB;
		logic [15:0] rdData;
		aisc_route_t route;
		logic [11:0] dmaAddr;
	} aisc_state_t;

	aisc_state_t st;
	aisc_state_t next_st;

	// Next selected input strictly after the given one, wrapping
	function automatic logic [4:0] nextSelected(
		input logic [31:0] mask,
		input logic [4:0]  from
	);
		logic [4:0] idx;
		logic       found;
		nextSelected = from;
		found = 1'b0;
		for (int k = 1; k <= 32; k++) begin
			idx = from + k[4:0];
			if (!found && mask[idx]) begin
				nextSelected = idx;
				found = 1'b1;
			end
		end
	endfunction

	logic        mode12;
	logic        altEn;
	logic        scanEn;
	logic        inOrder;
	logic [15:0] trioVisible;
	logic        useB;
	logic [4:0]  posSel;
	logic        negSel;
	logic        trioPos;
	logic [1:0]  trioNegSel;
	logic [4:0]  curInput;
	logic [11:0] scatter;

	always_comb begin
		next_st = st;
		mode12  = st.mode[AISC_MODE_12B];
		altEn   = st.mode[AISC_MODE_ALT];
		scanEn  = st.mode[AISC_MODE_SCAN];
		inOrder = st.mode[AISC_MODE_ORDER];
		// Hidden, not cleared: leaving the mode restores the fields
		trioVisible = mode12 ? 16'h0000 : st.trio; // [RULE6]

		// Register writes, unimplemented bits dropped
		if (regWr) begin
			unique case (regAddr)
				AISC_IDX_DEPTH:
					next_st.depth = regWrData & AISC_DEPTH_MASK; // [RULE2] [RULE21]
				AISC_IDX_TRIO: begin
					if (!mode12) begin
						next_st.trio = regWrData & AISC_TRIO_MASK; // [RULE6] [RULE21]
					end
				end
				AISC_IDX_CH0:
					next_st.ch0 = regWrData & AISC_CH0_MASK; // [RULE21]
				AISC_IDX_SCANH:
					next_st.scanMask[31:16] = regWrData; // [RULE11] [RULE12]
				AISC_IDX_SCANL:
					next_st.scanMask[15:0] = regWrData; // [RULE11]
				AISC_IDX_PINH: begin
					if (!SECOND_CONVERTER) begin
						next_st.pinMask[31:16] = regWrData; // [RULE14] [RULE15]
					end
				end
				AISC_IDX_PINL:
					next_st.pinMask[15:0] = regWrData; // [RULE14]
				AISC_IDX_MODE:
					next_st.mode = regWrData & AISC_MODE_MASK; // [RULE21]
				default: begin
				end
			endcase
		end

		// Read data, valid the cycle after the strobe
		next_st.rdData = 16'h0000;
		if (regRd) begin
			unique case (regAddr)
				AISC_IDX_DEPTH: next_st.rdData = st.depth; // [RULE2]
				AISC_IDX_TRIO:  next_st.rdData = trioVisible; // [RULE6]
				AISC_IDX_CH0:   next_st.rdData = st.ch0;
				AISC_IDX_SCANH: next_st.rdData = st.scanMask[31:16];
				AISC_IDX_SCANL: next_st.rdData = st.scanMask[15:0];
				AISC_IDX_PINH:
					next_st.rdData = SECOND_CONVERTER ?
						16'h0000 : st.pinMask[31:16]; // [RULE15]
				AISC_IDX_PINL:  next_st.rdData = st.pinMask[15:0];
				AISC_IDX_MODE:  next_st.rdData = st.mode;
				AISC_IDX_STAT:
					next_st.rdData = {9'h000, st.slotB, 1'b0, st.scanPtr};
				default:        next_st.rdData = 16'h0000; // [RULE16]
			endcase
		end

		// Sample slot and scan pointer
		useB = altEn && st.slotB; // [RULE18]
		if (!altEn) begin
			next_st.slotB = 1'b0; // [RULE18]
		end else if (sampleDone) begin
			next_st.slotB = !st.slotB; // [RULE18]
		end
		if (!scanEn) begin
			// Park on the lowest selected input; empty mask keeps pointer
			if (st.scanMask != 32'h00000000) begin
				next_st.scanPtr = nextSelected(st.scanMask, AISC_TOP_INPUT);
			end
		end else if (sampleDone && !useB) begin
			next_st.scanPtr = nextSelected(st.scanMask, st.scanPtr); // [RULE22]
		end

		// First channel selection
		if (useB) begin
			posSel = st.ch0[AISC_CH0_POS_B +: 5]; // [RULE10]
			negSel = st.ch0[AISC_CH0_NEG_B]; // [RULE8]
			trioPos = trioVisible[AISC_TRIO_POS_B]; // [RULE5]
			trioNegSel = trioVisible[AISC_TRIO_NEG_B +: 2]; // [RULE3]
		end else begin
			posSel = scanEn ? st.scanPtr :
				st.ch0[AISC_CH0_POS_A +: 5]; // [RULE9] [RULE19]
			negSel = st.ch0[AISC_CH0_NEG_A]; // [RULE7]
			trioPos = trioVisible[AISC_TRIO_POS_A]; // [RULE5]
			trioNegSel = trioVisible[AISC_TRIO_NEG_A +: 2]; // [RULE4]
		end
		curInput = posSel;
		next_st.route.slotB = useB;
		next_st.route.ch0Pos = posSel;
		// Missing inputs convert the low reference
		next_st.route.ch0PosToLowRef = !PRESENT[posSel]; // [RULE12]
		next_st.route.ch0PosToGround =
			PRESENT[posSel] && st.pinMask[posSel]; // [RULE13] [RULE14]
		next_st.route.ch0NegToAn1 = negSel; // [RULE7] [RULE8]
		// Codes 0x both select the reference
		next_st.route.trioPosHigh = trioPos; // [RULE5]
		next_st.route.trioNeg = trioNegSel[1] ?
			trioNegSel : 2'b00; // [RULE3] [RULE4]

		// Scatter base: input index times words per input
		scatter = 12'({7'h00, curInput} << st.depth[2:0]); // [RULE1] [RULE20]
		next_st.dmaAddr = inOrder ? orderAddr : scatter; // [RULE20]

		if (sys_rst) begin
			next_st = '0; // [RULE16]
		end
	end

	always_ff @(posedge clk_sys) begin
		st <= next_st;
	end

	assign regRdData = st.rdData;
	assign dmaAddr = st.dmaAddr;
	assign dmaWordsPerInput = 8'(8'h01 << st.depth[2:0]); // [RULE1]
	assign twelveBitMode = st.mode[AISC_MODE_12B]; // [RULE17]
	assign route = st.route;
	// Absent pins stay analog so they cannot disturb anything
	assign pinDigitalSelect = st.pinMask & PRESENT; // [RULE13] [RULE14]
endmodule
`default_nettype wire

// [hdl/aisc_pkg.sv]
// Register map, field layout and carrier types of the input select block
package aisc_pkg;
	localparam int AISC_AW = 4;
	localparam int AISC_DW = 16;
	// Register indices
	localparam logic [3:0] AISC_IDX_DEPTH = 4'h0;
	localparam logic [3:0] AISC_IDX_TRIO  = 4'h1;
	localparam logic [3:0] AISC_IDX_CH0   = 4'h2;
	localparam logic [3:0] AISC_IDX_SCANH = 4'h3;
	localparam logic [3:0] AISC_IDX_SCANL = 4'h4;
	localparam logic [3:0] AISC_IDX_PINH  = 4'h5;
	localparam logic [3:0] AISC_IDX_PINL  = 4'h6;
	localparam logic [3:0] AISC_IDX_MODE  = 4'h7;
	localparam logic [3:0] AISC_IDX_STAT  = 4'h8;
	// Field positions
	localparam int AISC_TRIO_POS_A = 0;
	localparam int AISC_TRIO_NEG_A = 1;
	localparam int AISC_TRIO_POS_B = 8;
	localparam int AISC_TRIO_NEG_B = 9;
	localparam int AISC_CH0_POS_A  = 0;
	localparam int AISC_CH0_NEG_A  = 7;
	localparam int AISC_CH0_POS_B  = 8;
	localparam int AISC_CH0_NEG_B  = 15;
	localparam int AISC_MODE_12B   = 0;
	localparam int AISC_MODE_ALT   = 1;
	localparam int AISC_MODE_SCAN  = 2;
	localparam int AISC_MODE_ORDER = 3;
	// Implemented-bit masks and reset value
	localparam logic [15:0] AISC_DEPTH_MASK = 16'h0007;
	localparam logic [15:0] AISC_TRIO_MASK  = 16'h0707;
	localparam logic [15:0] AISC_CH0_MASK   = 16'h9F9F;
	localparam logic [15:0] AISC_MODE_MASK  = 16'h000F;
	localparam logic [15:0] AISC_RST_VAL    = 16'h0000;
	localparam logic [4:0]  AISC_TOP_INPUT  = 5'h1F;

	// Input routing handed to the multiplexers
	typedef struct packed {
		logic       slotB;
		logic [4:0] ch0Pos;
		logic       ch0PosToLowRef;
		logic       ch0PosToGround;
		logic       ch0NegToAn1;
		logic       trioPosHigh;
		logic [1:0] trioNeg;
	} aisc_route_t;
endpackage
